/* pkg/acl_access_pkg.sv */
// Purpose: Shared constants for the per-port ACL indirect access block
// Assumes: Word-per-register AHB-Lite map, byte address = 4 * index
// Notes:   Indices keep the printed register numbers
package acl_access_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [10:0] IDX_STAGE_FIRST  = 11'h600;
  localparam logic [10:0] IDX_STAGE_LAST   = 11'h60F;
  localparam logic [10:0] IDX_STAGE_B      = 11'h60B;
  localparam logic [10:0] IDX_STAGE_C      = 11'h60C;
  localparam logic [10:0] IDX_STAGE_D      = 11'h60D;
  localparam logic [10:0] IDX_STAGE_E      = 11'h60E;
  localparam logic [10:0] IDX_STAGE_F      = 11'h60F;
  localparam logic [10:0] IDX_SELECT_HIGH  = 11'h610;
  localparam logic [10:0] IDX_SELECT_LOW   = 11'h611;
  localparam logic [10:0] IDX_CONTROL      = 11'h612;

  // ************************************************************
  // Entry geometry and field positions
  // ************************************************************
  localparam int          ENTRY_BYTES      = 16;
  localparam int          ENTRY_COUNT      = 16;
  localparam int          BYTE_MATCH_MODE  = 1;
  localparam int          BYTE_REMARK_MAP  = 11;
  localparam int          BYTE_FORWARD     = 13;
  localparam int          MATCH_MODE_LSB   = 4;
  localparam int          REMARK_LSB_BIT   = 7;
  localparam int          MAP_MODE_LSB     = 5;
  localparam int          FORWARD_MSB      = 5;
  localparam logic [7:0]  BYTE0_MASK       = 8'h0F;

  // ************************************************************
  // Transfer control register
  // ************************************************************
  localparam int          CTRL_WRITE_DONE  = 6;
  localparam int          CTRL_READ_DONE   = 5;
  localparam int          CTRL_DIRECTION   = 4;
  localparam logic [7:0]  STAGE_RESET      = 8'h00;
  localparam logic [7:0]  SELECT_RESET     = 8'h00;
  localparam logic [3:0]  INDEX_RESET      = 4'h0;
  localparam logic        DIRECTION_RESET  = 1'b0;
  localparam logic        DONE_RESET       = 1'b1;

  // ************************************************************
  // Transfer sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    XFER_IDLE   = 2'b00,
    XFER_ACCESS = 2'b01,
    XFER_LOAD   = 2'b10
  } xfer_state_type;

endpackage : acl_access_pkg

/* design/acl_entry_table.sv */
// Purpose: Entry storage with a byte-masked write port and two read ports
// Assumes: Reads are registered, one cycle of latency
// Notes:   Contents are data, not control, and are not reset
module acl_entry_table #(
  parameter int ENTRIES = 16,
  parameter int BYTES   = 16,
  parameter int IDX_W   = 4
) (
  input  wire logic               clk_i,
  input  wire logic               wr_en_i,
  input  wire logic [IDX_W-1:0]   wr_index_i,
  input  wire logic [BYTES-1:0]   wr_byte_en_i,
  input  wire logic [BYTES*8-1:0] wr_data_i,
  input  wire logic [IDX_W-1:0]   rd_index_i,
  output logic      [BYTES*8-1:0] rd_data_o,
  input  wire logic [IDX_W-1:0]   lk_index_i,
  output logic      [BYTES*8-1:0] lk_data_o
);

  logic [BYTES*8-1:0] mem [ENTRIES];

  // Only enabled bytes change; the rest of the entry is kept
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      for (int b = 0; b < BYTES; b++) begin
        if (wr_byte_en_i[b]) begin
          mem[wr_index_i][b*8 +: 8] <= wr_data_i[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    rd_data_o <= mem[rd_index_i];
  end

  always_ff @(posedge clk_i) begin
    lk_data_o <= mem[lk_index_i];
  end

endmodule : acl_entry_table

/* design/acl_table_indirect_access.sv */
// Purpose: Per-port indirect access to the ACL table over AHB-Lite
// Assumes: Single word transfers, one slave, data in the low byte
// Notes:   Reads take one wait state, writes none
module acl_table_indirect_access #(
  parameter int ENTRIES = 16
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic [3:0]  lookup_index_i,
  output logic      [5:0]  lookup_forward_map_o,
  output logic      [1:0]  lookup_map_mode_o,
  output logic      [1:0]  lookup_match_mode_o
);

  localparam int NB = acl_access_pkg::ENTRY_BYTES;

  // ************************************************************
  // Helpers
  // ************************************************************
  // Mask bit 15 picks byte 0 and mask bit 0 picks byte F
  function automatic logic [NB-1:0] stage_select(input logic [15:0] m);
    logic [NB-1:0] s;
    s = '0;
    for (int k = 0; k < NB; k++) begin
      s[k] = m[15-k];
    end
    return s;
  endfunction : stage_select

  function automatic logic reg_hit(input logic [31:0] a,
                                   input logic [10:0] idx);
    return (a[31:13] == 19'h00000) && (a[12:2] == idx);
  endfunction : reg_hit

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0]                        stage [NB];
  logic [7:0]                        select_high;
  logic [7:0]                        select_low;
  logic [3:0]                        entry_index;
  logic                              direction;
  logic                              write_done;
  logic                              read_done;
  acl_access_pkg::xfer_state_type    state;
  logic [NB-1:0]                     xfer_sel;
  logic [3:0]                        xfer_index;
  logic                              xfer_write;
  logic                              dp_write;
  logic                              dp_read;
  logic [31:0]                       dp_addr;
  logic [NB*8-1:0]                   tbl_rd_data;
  logic [NB*8-1:0]                   tbl_lk_data;
  logic [NB*8-1:0]                   stage_flat;
  logic [31:0]                       next_rdata;
  logic                              addr_accept;
  logic                              start_req;
  logic                              start;
  logic                              mem_write;

  assign addr_accept = hsel_i && htrans_i[1] && hready_i;
  // A write to any other register never starts a transfer
  assign start_req = dp_write &&
                     reg_hit(dp_addr, acl_access_pkg::IDX_SELECT_LOW);
  // Requests during a running transfer are dropped
  assign start     = start_req && (state == acl_access_pkg::XFER_IDLE);
  assign mem_write = (state == acl_access_pkg::XFER_ACCESS) && xfer_write;

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 32'h00000000;
    end else begin
      if (hready_i || dp_read) begin
        dp_write <= addr_accept && hwrite_i;
        dp_read  <= addr_accept && !hwrite_i && !dp_read;
      end
      if (addr_accept) begin
        dp_addr <= haddr_i;
      end
    end
  end

  // Wait state lets a read see the effect of the write just before it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hreadyout_o <= 1'b1;
      hrdata_o    <= 32'h00000000;
      hresp_o     <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
      if (addr_accept && !hwrite_i && hreadyout_o) begin
        hreadyout_o <= 1'b0;
      end else if (!hreadyout_o) begin
        hreadyout_o <= 1'b1;
        hrdata_o    <= next_rdata;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (reg_hit(dp_addr, acl_access_pkg::IDX_SELECT_HIGH)) begin
      next_rdata[7:0] = select_high;
    end else if (reg_hit(dp_addr, acl_access_pkg::IDX_SELECT_LOW)) begin
      next_rdata[7:0] = select_low;
    end else if (reg_hit(dp_addr, acl_access_pkg::IDX_CONTROL)) begin
      next_rdata[acl_access_pkg::CTRL_WRITE_DONE] = write_done;
      next_rdata[acl_access_pkg::CTRL_READ_DONE]  = read_done;
      next_rdata[acl_access_pkg::CTRL_DIRECTION]  = direction;
      next_rdata[3:0]                             = entry_index;
    end else begin
      for (int k = 0; k < NB; k++) begin
        if (reg_hit(dp_addr, acl_access_pkg::IDX_STAGE_FIRST +
                             11'(k))) begin
          next_rdata[7:0] = stage[k];
        end
      end
    end
  end

  // ************************************************************
  // Staging bytes
  // ************************************************************
  // Byte B holds remark LSB and map mode, D the forward map
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int k = 0; k < NB; k++) begin
        stage[k] <= acl_access_pkg::STAGE_RESET;
      end
    end else begin
      for (int k = 0; k < NB; k++) begin
        // Table data wins over a bus write landing in the same cycle
        if (state == acl_access_pkg::XFER_LOAD && xfer_sel[k]) begin
          stage[k] <= tbl_rd_data[k*8 +: 8];
        end else if (dp_write &&
                     reg_hit(dp_addr, acl_access_pkg::IDX_STAGE_FIRST +
                                      11'(k))) begin
          stage[k] <= (k == 0) ?
                      (hwdata_i[7:0] & acl_access_pkg::BYTE0_MASK) :
                      hwdata_i[7:0];
        end
      end
    end
  end

  always_comb begin
    stage_flat = '0;
    for (int k = 0; k < NB; k++) begin
      stage_flat[k*8 +: 8] = stage[k];
    end
  end

  // ************************************************************
  // Enable mask and control register
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      select_high <= acl_access_pkg::SELECT_RESET;
      select_low  <= acl_access_pkg::SELECT_RESET;
    end else if (dp_write) begin
      if (reg_hit(dp_addr, acl_access_pkg::IDX_SELECT_HIGH)) begin
        select_high <= hwdata_i[7:0];
      end
      if (reg_hit(dp_addr, acl_access_pkg::IDX_SELECT_LOW)) begin
        select_low <= hwdata_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      entry_index <= acl_access_pkg::INDEX_RESET;
      direction   <= acl_access_pkg::DIRECTION_RESET;
    end else if (dp_write &&
                 reg_hit(dp_addr, acl_access_pkg::IDX_CONTROL)) begin
      entry_index <= hwdata_i[3:0];
      direction   <= hwdata_i[acl_access_pkg::CTRL_DIRECTION];
    end
  end

  // ************************************************************
  // Transfer sequencer
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state      <= acl_access_pkg::XFER_IDLE;
      xfer_sel   <= '0;
      xfer_index <= acl_access_pkg::INDEX_RESET;
      xfer_write <= acl_access_pkg::DIRECTION_RESET;
    end else begin
      case (state)
        acl_access_pkg::XFER_IDLE: begin
          if (start) begin
            // The new low byte is used, not the old one
            xfer_sel   <= stage_select({select_high,
                                        hwdata_i[7:0]});
            xfer_index <= entry_index;
            xfer_write <= direction;
            state      <= acl_access_pkg::XFER_ACCESS;
          end
        end
        acl_access_pkg::XFER_ACCESS: begin
          state <= xfer_write ? acl_access_pkg::XFER_IDLE :
                                acl_access_pkg::XFER_LOAD;
        end
        acl_access_pkg::XFER_LOAD: begin
          state <= acl_access_pkg::XFER_IDLE;
        end
        default: begin
          state <= acl_access_pkg::XFER_IDLE;
        end
      endcase
    end
  end

  // Each direction's flag drops at its start and rises as the sequencer returns to idle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      write_done <= acl_access_pkg::DONE_RESET;
      read_done  <= acl_access_pkg::DONE_RESET;
    end else begin
      if (start && direction) begin
        write_done <= 1'b0;
      end else if (mem_write) begin
        write_done <= 1'b1;
      end
      if (start && !direction) begin
        read_done <= 1'b0;
      end else if (state == acl_access_pkg::XFER_LOAD) begin
        read_done <= 1'b1;
      end
    end
  end

  acl_entry_table #(
    .ENTRIES (ENTRIES),
    .BYTES   (NB),
    .IDX_W   (4)
  ) u_table (
    .clk_i        (clk_i),
    .wr_en_i      (mem_write),
    .wr_index_i   (xfer_index),
    .wr_byte_en_i (xfer_sel),
    .wr_data_i    (stage_flat),
    .rd_index_i   (xfer_index),
    .rd_data_o    (tbl_rd_data),
    .lk_index_i   (lookup_index_i),
    .lk_data_o    (tbl_lk_data)
  );

  // ************************************************************
  // Lookup outputs for the forwarding logic
  // ************************************************************
  // Bit n of the map enables forwarding toward port n+1
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lookup_forward_map_o <= 6'h00;
      lookup_map_mode_o    <= 2'h0;
      lookup_match_mode_o  <= 2'h0;
    end else begin
      lookup_forward_map_o <= tbl_lk_data[
        acl_access_pkg::BYTE_FORWARD*8 +: 6];
      lookup_map_mode_o    <= tbl_lk_data[
        acl_access_pkg::BYTE_REMARK_MAP*8 +
        acl_access_pkg::MAP_MODE_LSB +: 2];
      lookup_match_mode_o  <= tbl_lk_data[
        acl_access_pkg::BYTE_MATCH_MODE*8 +
        acl_access_pkg::MATCH_MODE_LSB +: 2];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  // Entries whose forward byte was written; unwritten ones hold X
  logic [ENTRIES-1:0] fwd_known;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fwd_known <= '0;
    end else if (mem_write && xfer_sel[acl_access_pkg::BYTE_FORWARD]) begin
      fwd_known[xfer_index] <= 1'b1;
    end
  end

  sequence s_write_runs;
    !write_done ##1 write_done;
  endsequence

  sequence s_read_runs;
    !read_done ##1 !read_done ##1 read_done;
  endsequence

  property p_write_flag;
    @(posedge clk_i) disable iff (reset_i)
    start && direction |=> s_write_runs;
  endproperty
  a_write_flag: assert property (p_write_flag)
    else $error("write flag sequence wrong");

  property p_read_flag;
    @(posedge clk_i) disable iff (reset_i)
    start && !direction |=> s_read_runs;
  endproperty
  a_read_flag: assert property (p_read_flag)
    else $error("read flag sequence wrong");

  property p_other_no_start;
    @(posedge clk_i) disable iff (reset_i)
    state == acl_access_pkg::XFER_IDLE && !start_req |=>
      state == acl_access_pkg::XFER_IDLE;
  endproperty
  a_other_no_start: assert property (p_other_no_start)
    else $error("transfer began without low enable write");

  property p_select_map;
    @(posedge clk_i) disable iff (reset_i)
    start |=> xfer_sel[0] == select_high[7] &&
              xfer_sel[7] == select_high[0] &&
              xfer_sel[8] == select_low[7] &&
              xfer_sel[15] == select_low[0];
  endproperty
  a_select_map: assert property (p_select_map)
    else $error("enable bit to byte mapping wrong");

  property p_load_untouched;
    @(posedge clk_i) disable iff (reset_i)
    state == acl_access_pkg::XFER_LOAD && !xfer_sel[15] &&
    !(dp_write && reg_hit(dp_addr, acl_access_pkg::IDX_STAGE_F)) |=>
      $stable(stage[15]);
  endproperty
  a_load_untouched: assert property (p_load_untouched)
    else $error("unselected staging byte changed");

  property p_reset_flags;
    @(posedge clk_i)
    reset_i |=> write_done && read_done &&
                state == acl_access_pkg::XFER_IDLE;
  endproperty
  a_reset_flags: assert property (p_reset_flags)
    else $error("flags not set after reset");

  property p_busy_ignore;
    @(posedge clk_i) disable iff (reset_i)
    start_req && state != acl_access_pkg::XFER_IDLE |=>
      $stable(xfer_index) && $stable(xfer_sel);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("start accepted while busy");

  property p_forward_map;
    @(posedge clk_i) disable iff (reset_i)
    fwd_known[lookup_index_i] |=> ##1 lookup_forward_map_o ==
        $past(tbl_lk_data[acl_access_pkg::BYTE_FORWARD*8 +: 6]);
  endproperty
  a_forward_map: assert property (p_forward_map)
    else $error("forward map output mismatch");

  property p_read_wait;
    @(posedge clk_i) disable iff (reset_i)
    addr_accept && !hwrite_i && hreadyout_o |=>
      !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");

endmodule : acl_table_indirect_access

/* verification/acl_table_indirect_access_tb.sv */
// Purpose: Self-checking bench for the ACL indirect access block
// Assumes: Bus master waits on hready, entry 3 used for all transfers
// Notes:   Table bytes are seen only through staging reads and lookup
module acl_table_indirect_access_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Signals
  // ************************************************************
  logic        clk_i          = 1'b0;
  logic        reset_i        = 1'b1;
  logic        hsel_i         = 1'b0;
  logic [31:0] haddr_i        = 32'h0000_0000;
  logic [1:0]  htrans_i       = 2'b00;
  logic        hwrite_i       = 1'b0;
  logic [2:0]  hsize_i        = 3'b010;
  logic [31:0] hwdata_i       = 32'h0000_0000;
  logic [3:0]  lookup_index_i = 4'h0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic [5:0]  lookup_forward_map_o;
  logic [1:0]  lookup_map_mode_o;
  logic [1:0]  lookup_match_mode_o;
  int          num_errors     = 0;
  int          checks_done    = 0;
  logic [7:0]  entry_a [16];
  logic [31:0] rd_val;
  logic [7:0]  exp_b;

  always #20 clk_i = ~clk_i;

  acl_table_indirect_access #(
    .ENTRIES (16)
  ) dut_u (
    .clk_i                (clk_i),
    .reset_i              (reset_i),
    .hsel_i               (hsel_i),
    .haddr_i              (haddr_i),
    .htrans_i             (htrans_i),
    .hwrite_i             (hwrite_i),
    .hsize_i              (hsize_i),
    .hwdata_i             (hwdata_i),
    .hready_i             (hreadyout_o),
    .hrdata_o             (hrdata_o),
    .hreadyout_o          (hreadyout_o),
    .hresp_o              (hresp_o),
    .lookup_index_i       (lookup_index_i),
    .lookup_forward_map_o (lookup_forward_map_o),
    .lookup_map_mode_o    (lookup_map_mode_o),
    .lookup_match_mode_o  (lookup_match_mode_o)
  );

  // ************************************************************
  // Reporting
  // ************************************************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // ************************************************************
  // Bus access
  // ************************************************************
  // Samples hready at the edge; a stuck slave ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) begin
      n++;
      if (n > 50) begin
        num_errors++;
        $display("mismatch hready expected 1 seen %b", hreadyout_o);
        wrap_up();
      end
      @(posedge clk_i);
    end
  endtask : wait_ready

  // Called just after a rising edge; returns just after one
  task automatic bus_xfer(input logic [10:0] idx, input logic wr,
                          input logic [7:0] wd);
    hsel_i   <= 1'b1;
    haddr_i  <= {19'h0_0000, idx, 2'b00};
    htrans_i <= 2'b10;
    hwrite_i <= wr;
    wait_ready();
    htrans_i <= 2'b00;
    hwdata_i <= {24'h00_0000, wd};
    wait_ready();
    rd_val = hrdata_o;
    check("response", 32'h0000_0000, {31'h0000_0000, hresp_o});
  endtask : bus_xfer

  task automatic bus_write(input logic [10:0] idx, input logic [7:0] d);
    bus_xfer(idx, 1'b1, d);
  endtask : bus_write

  task automatic bus_read(input logic [10:0] idx);
    bus_xfer(idx, 1'b0, 8'h00);
  endtask : bus_read

  function automatic logic [10:0] stage(input int k);
    return acl_access_pkg::IDX_STAGE_FIRST + 11'(k);
  endfunction : stage

  // Mask low goes last because that write launches the transfer
  task automatic start(input logic [7:0] hi, input logic [7:0] ctrl,
                       input logic [7:0] lo);
    bus_write(acl_access_pkg::IDX_SELECT_HIGH, hi);
    bus_write(acl_access_pkg::IDX_CONTROL, ctrl);
    bus_write(acl_access_pkg::IDX_SELECT_LOW, lo);
  endtask : start

  task automatic poll_done(input int b);
    int n;
    for (n = 0; n < 20; n++) begin
      bus_read(acl_access_pkg::IDX_CONTROL);
      if (rd_val[b] === 1'b1) begin
        break;
      end
    end
    check("done flag", 32'h0000_0001, {31'h0000_0000, rd_val[b]});
  endtask : poll_done

  task automatic check_lookup(input logic [5:0] fwd, input logic [1:0] mm,
                              input logic [1:0] match);
    lookup_index_i <= 4'h3;
    repeat (3) @(posedge clk_i);
    check("forward map", {26'h0, fwd}, {26'h0, lookup_forward_map_o});
    check("map mode", {30'h0, mm}, {30'h0, lookup_map_mode_o});
    check("match mode", {30'h0, match}, {30'h0, lookup_match_mode_o});
  endtask : check_lookup

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    entry_a = '{8'h0A, 8'h20, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC,
                8'hDE, 8'hF0, 8'h03, 8'hC0, 8'h00, 8'h05, 8'h5A, 8'hA5};
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    bus_read(acl_access_pkg::IDX_CONTROL);
    check("control reset", 32'h0000_0060, rd_val);
    bus_read(acl_access_pkg::IDX_SELECT_LOW);
    check("mask low reset", 32'h0000_0000, rd_val);
    bus_read(acl_access_pkg::IDX_SELECT_HIGH);
    check("mask high reset", 32'h0000_0000, rd_val);
    bus_write(11'h613, 8'hFF);
    bus_read(11'h613);
    check("unmapped", 32'h0000_0000, rd_val);
    bus_read(acl_access_pkg::IDX_CONTROL);
    check("no start", 32'h0000_0060, rd_val);
    // Full write of entry 3, every byte selected
    for (int k = 0; k < 16; k++) begin
      bus_write(stage(k), entry_a[k]);
    end
    start(8'hFF, 8'h13, 8'hFF);
    poll_done(6);
    check("control after write", 32'h0000_0073, rd_val);
    check_lookup(6'h05, 2'b10, 2'b10);
    // Partial read into cleared staging: bytes 1, B and D only
    for (int k = 0; k < 16; k++) begin
      bus_write(stage(k), 8'h00);
    end
    start(8'h40, 8'h03, 8'h14);
    poll_done(5);
    check("control after read", 32'h0000_0063, rd_val);
    for (int k = 0; k < 16; k++) begin
      exp_b = (k == 1 || k == 11 || k == 13) ? entry_a[k] : 8'h00;
      bus_read(stage(k));
      check("partial read", {24'h0, exp_b}, rd_val);
    end
    // Partial write of byte D only; byte 1 staging must not reach table
    bus_write(acl_access_pkg::IDX_STAGE_D, 8'h3A);
    bus_write(stage(1), 8'h10);
    start(8'h00, 8'h13, 8'h04);
    poll_done(6);
    check_lookup(6'h3A, 2'b10, 2'b10);
    // Writes to staging D, mask high and control must not launch
    bus_write(acl_access_pkg::IDX_STAGE_D, 8'h01);
    bus_write(acl_access_pkg::IDX_SELECT_HIGH, 8'hFF);
    bus_write(acl_access_pkg::IDX_CONTROL, 8'h13);
    check_lookup(6'h3A, 2'b10, 2'b10);
    // Full read back shows the table after the partial write
    entry_a[13] = 8'h3A;
    start(8'hFF, 8'h03, 8'hFF);
    poll_done(5);
    for (int k = 0; k < 16; k++) begin
      bus_read(stage(k));
      check("full read", {24'h0, entry_a[k]}, rd_val);
    end
    wrap_up();
  end

endmodule : acl_table_indirect_access_tb
